// file: sensor_cmd_regs.sv
// sensor end: command-mode entry, control/status and test control registers
//
// Behaviour
// - key 16F4h written in window enters command
// - status at 82h/83h, bit15 diagnostic present
// - bit14 write-only override forces diagnostics off
// - bit12 reports low supply voltage
// - bit11 pump clock, set after write enable
// - bit8 sticky corrected memory error flag
// - bit7 sticky uncorrectable memory error flag
// - bit6 sticky field loss, gated diagnostics
// - bit5 sticky broken bond wire flag
// - bit4 checksum mismatch captured at start-up
// - test control bit11 write enable, 96h
// - after unlock read all but test control (reads zero), write customer only
// - writes to reserved areas are dropped
// - master waits programming time after memory-region writes only
// - master enables pump and write first
// - master reads 8h..Fh for checksum
// - command byte: region, address, read bit
// - crc8 poly 107h, start FFh, msb first
// - write is command plus two data bytes
// - locked device ignores link except the key while a diagnostic is present, analog mode
//
// The Wishbone slave port was decided locally.
`default_nettype none

module sensor_cmd_regs
  import cmd_regs_pkg::*;
#(
  parameter int ENTRY_CYCLES = ENTRY_CYC
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  single_wire_if.sensor    link,
  input  wire logic        undervoltage_i,
  input  wire logic        nv_readout_i,
  input  wire logic        nv_single_err_i,
  input  wire logic        nv_double_err_i,
  input  wire logic        field_missing_i,
  input  wire logic        field_check_en_i,
  input  wire logic        bond_open_i,
  input  wire logic        startup_check_i,
  input  wire logic        crc_mismatch_i,
  input  wire logic [15:0] nv_rdata_i,
  output var  logic        command_mode_o,
  output var  logic        diag_mode_o,
  output var  logic        pump_clock_on_o,
  output var  logic        nv_write_en_o,
  output var  logic        nv_we_o,
  output var  logic [3:0]  nv_addr_o,
  output var  logic [15:0] nv_wdata_o
);

  localparam int CW = $clog2(ENTRY_CYCLES + 1);

  // ==========================================================================
  // state
  dev_state_t  state_r,     state_nxt;
  logic [CW-1:0] win_r,     win_nxt;
  logic        ovr_r,       ovr_nxt;
  logic        pump_r,      pump_nxt;
  logic        wen_r,       wen_nxt;
  logic        serr_r,      serr_nxt;
  logic        derr_r,      derr_nxt;
  logic        field_r,     field_nxt;
  logic        bond_r,      bond_nxt;
  logic        crc_r,       crc_nxt;
  logic        pend_r,      pend_nxt;
  logic [7:0]  pcmd_r,      pcmd_nxt;
  logic        rsp_v_r,     rsp_v_nxt;
  logic [15:0] rsp_d_r,     rsp_d_nxt;
  logic        mode_r,      mode_nxt;
  logic        diag_r,      diag_nxt;
  logic        we_r,        we_nxt;
  logic [3:0]  addr_r,      addr_nxt;
  logic [15:0] wdata_r,     wdata_nxt;

  logic [2:0]  region;
  logic [3:0]  addr;
  logic        rd;
  logic        diag_present;
  logic [15:0] status;

  // ==========================================================================
  // decode and status word
  always_comb begin
    region = link.cmd_byte[7:5];
    addr   = link.cmd_byte[4:1];
    rd     = link.cmd_byte[0];
    // field loss only counts once its detection is enabled
    diag_present = derr_r | bond_r | crc_r | undervoltage_i
                 | (field_r & field_check_en_i);
    status = WORD_RST;
    status[BIT_DIAG]  = diag_present;
    status[BIT_UV]    = undervoltage_i;
    status[BIT_PUMP]  = pump_r;
    status[BIT_SERR]  = serr_r;
    status[BIT_DERR]  = derr_r;
    status[BIT_FIELD] = field_r;
    status[BIT_BOND]  = bond_r;
    status[BIT_CRC]   = crc_r;
  end

  // ==========================================================================
  // next values
  always_comb begin
    state_nxt = state_r;
    win_nxt   = win_r;
    ovr_nxt   = ovr_r;
    pump_nxt  = pump_r;
    wen_nxt   = wen_r;
    pend_nxt  = 1'b0;
    pcmd_nxt  = pcmd_r;
    rsp_v_nxt = 1'b0;
    rsp_d_nxt = rsp_d_r;
    we_nxt    = 1'b0;
    addr_nxt  = addr_r;
    wdata_nxt = wdata_r;

    // sticky flags only rise and only reset drops them; the checksum flag is reloaded at each start-up check
    serr_nxt  = serr_r | (nv_readout_i & nv_single_err_i);
    derr_nxt  = derr_r | (nv_readout_i & nv_double_err_i);
    field_nxt = field_r | field_missing_i;
    bond_nxt  = bond_r | bond_open_i;
    crc_nxt   = startup_check_i ? crc_mismatch_i : crc_r;

    case (state_r)
      ST_WAIT_KEY: begin
        if (win_r == CW'(ENTRY_CYCLES - 1)) begin
          state_nxt = ST_NORMAL;
        end else begin
          win_nxt = win_r + 1'b1;
        end
      end
      ST_COMMAND: begin
        if (link.cmd_valid) begin
          if (rd) begin
            pend_nxt = 1'b1;
            pcmd_nxt = link.cmd_byte;
            addr_nxt = addr;
          end else if (region == REGION_REG) begin
            case (link.cmd_byte)
              CMD_CTRL_WR: begin
                ovr_nxt  = link.cmd_data[BIT_OVR];
                pump_nxt = link.cmd_data[BIT_PUMP];
              end
              CMD_TEST_WR: begin
                wen_nxt = link.cmd_data[BIT_WEN];
              end
              default: begin
              end
            endcase
          end else if (region == REGION_NV && addr >= CUST_FIRST) begin
            // without pump and write enable the cells are not programmed
            we_nxt    = wen_r & pump_r;
            addr_nxt  = addr;
            wdata_nxt = link.cmd_data;
          end
          // any other write falls through untouched
        end
      end
      ST_NORMAL: begin
      end
      default: begin
        state_nxt = ST_NORMAL;
      end
    endcase

    // a device stuck in diagnostics may still be unlocked later
    if (link.cmd_valid && link.cmd_byte == CMD_KEY_WR && link.cmd_data == UNLOCK_KEY
        && (state_r == ST_WAIT_KEY || (state_r == ST_NORMAL && diag_present))) begin
      state_nxt = ST_COMMAND;
    end

    // read answer two cycles after the command, memory needs one for its data
    if (pend_r) begin
      rsp_v_nxt = 1'b1;
      if (pcmd_r == CMD_CTRL_RD) begin
        rsp_d_nxt = status;
      end else if (pcmd_r[7:5] == REGION_NV) begin
        rsp_d_nxt = nv_rdata_i;
      end else begin
        rsp_d_nxt = WORD_RST;
      end
    end

    mode_nxt = (state_nxt == ST_COMMAND);
    diag_nxt = diag_present & ~ovr_r;
  end

  // ==========================================================================
  // registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      state_r <= ST_WAIT_KEY;
      win_r   <= '0;
      ovr_r   <= BIT_RST;
      pump_r  <= BIT_RST;
      wen_r   <= BIT_RST;
      serr_r  <= BIT_RST;
      derr_r  <= BIT_RST;
      field_r <= BIT_RST;
      bond_r  <= BIT_RST;
      crc_r   <= BIT_RST;
      pend_r  <= BIT_RST;
      pcmd_r  <= 8'h00;
      rsp_v_r <= BIT_RST;
      rsp_d_r <= WORD_RST;
      mode_r  <= BIT_RST;
      diag_r  <= BIT_RST;
      we_r    <= BIT_RST;
      addr_r  <= 4'h0;
      wdata_r <= WORD_RST;
    end else begin
      state_r <= state_nxt;
      win_r   <= win_nxt;
      ovr_r   <= ovr_nxt;
      pump_r  <= pump_nxt;
      wen_r   <= wen_nxt;
      serr_r  <= serr_nxt;
      derr_r  <= derr_nxt;
      field_r <= field_nxt;
      bond_r  <= bond_nxt;
      crc_r   <= crc_nxt;
      pend_r  <= pend_nxt;
      pcmd_r  <= pcmd_nxt;
      rsp_v_r <= rsp_v_nxt;
      rsp_d_r <= rsp_d_nxt;
      mode_r  <= mode_nxt;
      diag_r  <= diag_nxt;
      we_r    <= we_nxt;
      addr_r  <= addr_nxt;
      wdata_r <= wdata_nxt;
    end
  end

  assign link.rsp_valid  = rsp_v_r;
  assign link.rsp_data   = rsp_d_r;
  assign command_mode_o  = mode_r;
  assign diag_mode_o     = diag_r;
  assign pump_clock_on_o = pump_r;
  assign nv_write_en_o   = wen_r;
  assign nv_we_o         = we_r;
  assign nv_addr_o       = addr_r;
  assign nv_wdata_o      = wdata_r;

endmodule

`default_nettype wire

// file: cmd_regs_pkg.sv
// shared constants and types for the sensor command-mode register link
`default_nettype none

package cmd_regs_pkg;

  // ==========================================================================
  // command bytes and regions
  localparam logic [7:0]  CMD_CTRL_WR  = 8'h82;
  localparam logic [7:0]  CMD_CTRL_RD  = 8'h83;
  localparam logic [7:0]  CMD_KEY_WR   = 8'h94;
  localparam logic [7:0]  CMD_TEST_WR  = 8'h96;
  localparam logic [7:0]  CMD_TEST_RD  = 8'h97;
  localparam logic [2:0]  REGION_NV    = 3'h0;
  localparam logic [2:0]  REGION_REG   = 3'h4;
  localparam logic [3:0]  CUST_FIRST   = 4'h8;
  localparam logic [15:0] UNLOCK_KEY   = 16'h16f4;

  // ==========================================================================
  // field positions and reset values
  localparam int          BIT_DIAG     = 15;
  localparam int          BIT_OVR      = 14;
  localparam int          BIT_UV       = 12;
  localparam int          BIT_PUMP     = 11;
  localparam int          BIT_SERR     = 8;
  localparam int          BIT_DERR     = 7;
  localparam int          BIT_FIELD    = 6;
  localparam int          BIT_BOND     = 5;
  localparam int          BIT_CRC      = 4;
  localparam int          BIT_WEN      = 11;
  localparam logic        BIT_RST      = 1'b0;
  localparam logic [15:0] WORD_RST     = 16'h0000;

  // ==========================================================================
  // checksum
  localparam logic [7:0]  CRC_POLY     = 8'h07;
  localparam logic [7:0]  CRC_INIT     = 8'hff;

  // ==========================================================================
  // timing at 20 MHz
  localparam int          CLK_MHZ      = 20;
  localparam int          T_ENTRY_US   = 100;
  localparam int          ENTRY_CYC    = T_ENTRY_US * CLK_MHZ;
  localparam int          T_PROG_US    = 20;
  localparam int          PROG_CYC     = T_PROG_US * CLK_MHZ;
  localparam int          RSP_TIMEOUT  = 16;

  // ==========================================================================
  // wishbone map of the programming master
  localparam logic [7:0]  ADR_CMD      = 8'h00;
  localparam logic [7:0]  ADR_STATUS   = 8'h04;
  localparam logic [7:0]  ADR_RDATA    = 8'h08;
  localparam logic [7:0]  ADR_CTRL     = 8'h0c;

  typedef enum logic [1:0] {ST_WAIT_KEY, ST_COMMAND, ST_NORMAL} dev_state_t;
  typedef enum logic [1:0] {MS_IDLE, MS_WAIT_RSP, MS_PROG} mst_state_t;

  // one word, msb first, each data bit shifted in at the low end; this form is the
  // one whose result over 8h..Fh lands in the low byte of Fh and checks back to zero
  function automatic logic [7:0] crc_step(input logic [7:0] crc, input logic [15:0] d);
    logic [7:0] c;
    logic       fb;
    c = crc;
    for (int i = 15; i >= 0; i--) begin
      fb = c[7];
      c  = {c[6:0], d[i]} ^ (fb ? CRC_POLY : 8'h00);
    end
    return c;
  endfunction

endpackage

`default_nettype wire

// file: single_wire_if.sv
// transaction-level carrier of the single-wire programming link
`default_nettype none

interface single_wire_if;
  logic        cmd_valid;
  logic [7:0]  cmd_byte;
  logic [15:0] cmd_data;
  logic        rsp_valid;
  logic [15:0] rsp_data;

  modport prog_master (output cmd_valid, output cmd_byte, output cmd_data,
                       input rsp_valid, input rsp_data);
  modport sensor (input cmd_valid, input cmd_byte, input cmd_data,
                  output rsp_valid, output rsp_data);
endinterface

`default_nettype wire

// file: prog_master.sv
// programming-master end: wishbone-controlled command sender with checksum
`default_nettype none

module prog_master
  import cmd_regs_pkg::*;
#(
  parameter int PROG_CYCLES = PROG_CYC
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic        wb_we_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  output var  logic [31:0] wb_dat_o,
  output var  logic        wb_ack_o,
  single_wire_if.prog_master link
);

  // ==========================================================================
  // state
  mst_state_t  st_r,    st_nxt;
  logic [15:0] cnt_r,   cnt_nxt;
  logic        ack_r,   ack_nxt;
  logic [31:0] dat_r,   dat_nxt;
  logic        cv_r,    cv_nxt;
  logic [7:0]  cb_r,    cb_nxt;
  logic [15:0] cd_r,    cd_nxt;
  logic [15:0] rdat_r,  rdat_nxt;
  logic        done_r,  done_nxt;
  logic        ref_r,   ref_nxt;
  logic        tmo_r,   tmo_nxt;
  logic        wen_r,   wen_nxt;
  logic        pump_r,  pump_nxt;
  logic [7:0]  crc_r,   crc_nxt;

  logic        wr;
  logic        nv_wr;

  // ==========================================================================
  // next values
  always_comb begin
    st_nxt   = st_r;
    cnt_nxt  = cnt_r;
    cv_nxt   = 1'b0;
    cb_nxt   = cb_r;
    cd_nxt   = cd_r;
    rdat_nxt = rdat_r;
    done_nxt = done_r;
    ref_nxt  = ref_r;
    tmo_nxt  = tmo_r;
    wen_nxt  = wen_r;
    pump_nxt = pump_r;
    crc_nxt  = crc_r;

    ack_nxt = wb_cyc_i & wb_stb_i & ~ack_r;
    wr      = ack_nxt & wb_we_i;
    nv_wr   = (wb_dat_i[7:5] == REGION_NV) & ~wb_dat_i[0];

    case (wb_adr_i)
      ADR_STATUS: dat_nxt = {16'h0000, crc_r, 4'h0, tmo_r, ref_r, done_r, st_r != MS_IDLE};
      ADR_RDATA:  dat_nxt = {16'h0000, rdat_r};
      default:    dat_nxt = 32'h0000_0000;
    endcase

    // clears come first so that an event in the same cycle wins
    if (wr && wb_adr_i == ADR_CTRL && wb_sel_i[0]) begin
      if (wb_dat_i[0]) begin
        crc_nxt = CRC_INIT;
      end
      if (wb_dat_i[1]) begin
        ref_nxt = 1'b0;
        tmo_nxt = 1'b0;
        done_nxt = 1'b0;
      end
    end

    case (st_r)
      MS_IDLE: begin
        if (wr && wb_adr_i == ADR_CMD && wb_sel_i == 4'hf) begin
          if (wb_dat_i[7:0] == CMD_CTRL_WR && wb_dat_i[16 + BIT_PUMP] && !wen_r) begin
            ref_nxt = 1'b1;
          end else if (nv_wr && !(wen_r && pump_r)) begin
            ref_nxt = 1'b1;
          end else begin
            cv_nxt = 1'b1;
            cb_nxt = wb_dat_i[7:0];
            cd_nxt = wb_dat_i[31:16];
            cnt_nxt = 16'h0000;
            if (wb_dat_i[7:0] == CMD_TEST_WR) begin
              wen_nxt = wb_dat_i[16 + BIT_WEN];
            end
            if (wb_dat_i[7:0] == CMD_CTRL_WR) begin
              pump_nxt = wb_dat_i[16 + BIT_PUMP];
            end
            if (wb_dat_i[0]) begin
              st_nxt = MS_WAIT_RSP;
              done_nxt = 1'b0;
            end else if (nv_wr) begin
              st_nxt = MS_PROG;
            end
          end
        end else if (wr && wb_adr_i == ADR_CMD) begin
          ref_nxt = 1'b1;
        end
      end
      MS_WAIT_RSP: begin
        if (link.rsp_valid) begin
          st_nxt   = MS_IDLE;
          rdat_nxt = link.rsp_data;
          done_nxt = 1'b1;
          if (cb_r[7:5] == REGION_NV && cb_r[4:1] >= CUST_FIRST) begin
            crc_nxt = crc_step(crc_r, link.rsp_data);
          end
        end else if (cnt_r == 16'(RSP_TIMEOUT - 1)) begin
          st_nxt  = MS_IDLE;
          tmo_nxt = 1'b1;
        end else begin
          cnt_nxt = cnt_r + 16'h0001;
        end
      end
      MS_PROG: begin
        if (cnt_r == 16'(PROG_CYCLES - 1)) begin
          st_nxt = MS_IDLE;
        end else begin
          cnt_nxt = cnt_r + 16'h0001;
        end
      end
      default: begin
        st_nxt = MS_IDLE;
      end
    endcase

    // refused while busy
    if (wr && wb_adr_i == ADR_CMD && st_r != MS_IDLE) begin
      ref_nxt = 1'b1;
    end
  end

  // ==========================================================================
  // registers
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st_r   <= MS_IDLE;
      cnt_r  <= 16'h0000;
      ack_r  <= 1'b0;
      dat_r  <= 32'h0000_0000;
      cv_r   <= 1'b0;
      cb_r   <= 8'h00;
      cd_r   <= WORD_RST;
      rdat_r <= WORD_RST;
      done_r <= 1'b0;
      ref_r  <= 1'b0;
      tmo_r  <= 1'b0;
      wen_r  <= BIT_RST;
      pump_r <= BIT_RST;
      crc_r  <= CRC_INIT;
    end else begin
      st_r   <= st_nxt;
      cnt_r  <= cnt_nxt;
      ack_r  <= ack_nxt;
      dat_r  <= dat_nxt;
      cv_r   <= cv_nxt;
      cb_r   <= cb_nxt;
      cd_r   <= cd_nxt;
      rdat_r <= rdat_nxt;
      done_r <= done_nxt;
      ref_r  <= ref_nxt;
      tmo_r  <= tmo_nxt;
      wen_r  <= wen_nxt;
      pump_r <= pump_nxt;
      crc_r  <= crc_nxt;
    end
  end

  assign wb_ack_o       = ack_r;
  assign wb_dat_o       = dat_r;
  assign link.cmd_valid = cv_r;
  assign link.cmd_byte  = cb_r;
  assign link.cmd_data  = cd_r;

endmodule

`default_nettype wire

// file: cmd_regs_props.sv
// assertion checker for the single-wire link between master and sensor
`default_nettype none

module cmd_regs_props
  import cmd_regs_pkg::*;
#(
  parameter int ENTRY_CYCLES = ENTRY_CYC
) (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        cmd_valid,
  input  wire logic [7:0]  cmd_byte,
  input  wire logic [15:0] cmd_data,
  input  wire logic        rsp_valid,
  input  wire logic [15:0] rsp_data,
  input  wire logic        command_mode_o
);
  timeunit 1ns;
  timeprecision 1ns;

  // ==========================================================================
  // cycles since reset, saturating so a long run never wraps into the window
  logic [15:0] age_r;
  logic [15:0] age_nxt;
  logic        key_ok;

  always_comb begin
    age_nxt = age_r;
    if (rst_i) begin
      age_nxt = 16'h0000;
    end else if (age_r != 16'hffff) begin
      age_nxt = age_r + 16'h0001;
    end
  end

  always_ff @(posedge clk_i) begin
    age_r <= age_nxt;
  end

  assign key_ok = cmd_valid && cmd_byte == CMD_KEY_WR && cmd_data == UNLOCK_KEY;

  // ==========================================================================
  // properties
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);

  sequence s_read_req;
    cmd_valid && cmd_byte[0] && command_mode_o;
  endsequence

  sequence s_answer;
    !rsp_valid ##1 rsp_valid;
  endsequence

  chk_read_answer: assert property (s_read_req |=> s_answer)
    else $error("read command not answered two cycles later");
  chk_write_silent: assert property (cmd_valid && !cmd_byte[0] |=> !rsp_valid [*2])
    else $error("write command got an answer");
  chk_locked_silent: assert property (cmd_valid && !command_mode_o |-> ##2 !rsp_valid)
    else $error("locked sensor answered");
  chk_cmd_pulse: assert property (cmd_valid |=> !cmd_valid)
    else $error("command valid longer than one cycle");
  chk_rsp_pulse: assert property (rsp_valid |=> !rsp_valid)
    else $error("answer valid longer than one cycle");
  chk_rsp_hold: assert property (!rsp_valid |-> $stable(rsp_data))
    else $error("answer data moved without an answer");
  chk_key_entry: assert property (key_ok && int'(age_r) < ENTRY_CYCLES - 2 |=> command_mode_o)
    else $error("key inside window did not unlock");
  chk_entry_cause: assert property (!command_mode_o && !key_ok |=> !command_mode_o)
    else $error("command mode entered without key");
  chk_mode_kept: assert property (command_mode_o |=> command_mode_o)
    else $error("command mode left without reset");

endmodule

`default_nettype wire

// file: testbench.sv
// self-checking bench joining the programming master and the sensor
`default_nettype none

module testbench
  import cmd_regs_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;

  localparam int ENTRY = 200;
  localparam int PROG  = 8;

  logic        clk_i, rst_i, wb_we_i, wb_cyc_i, wb_stb_i, wb_ack_o;
  logic [7:0]  wb_adr_i;
  logic [31:0] wb_dat_i, wb_dat_o;
  logic [3:0]  wb_sel_i;
  logic        undervoltage_i, nv_readout_i, nv_single_err_i, nv_double_err_i;
  logic        field_missing_i, field_check_en_i, bond_open_i, startup_check_i;
  logic        crc_mismatch_i, command_mode_o, diag_mode_o, pump_clock_on_o;
  logic        nv_write_en_o, nv_we_o;
  logic [3:0]  nv_addr_o, we_addr;
  logic [15:0] nv_rdata_i, nv_wdata_o, we_data;
  logic [15:0] mem [16];
  int          errors, checks, we_cnt;

  single_wire_if link ();
  prog_master #(.PROG_CYCLES(PROG)) prog_master_i (.clk_i(clk_i), .rst_i(rst_i),
    .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i),
    .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .link(link));
  sensor_cmd_regs #(.ENTRY_CYCLES(ENTRY)) sensor_cmd_regs_i (.clk_i(clk_i), .rst_i(rst_i),
    .link(link), .undervoltage_i(undervoltage_i), .nv_readout_i(nv_readout_i),
    .nv_single_err_i(nv_single_err_i), .nv_double_err_i(nv_double_err_i),
    .field_missing_i(field_missing_i), .field_check_en_i(field_check_en_i),
    .bond_open_i(bond_open_i), .startup_check_i(startup_check_i),
    .crc_mismatch_i(crc_mismatch_i), .nv_rdata_i(nv_rdata_i),
    .command_mode_o(command_mode_o), .diag_mode_o(diag_mode_o),
    .pump_clock_on_o(pump_clock_on_o), .nv_write_en_o(nv_write_en_o), .nv_we_o(nv_we_o),
    .nv_addr_o(nv_addr_o), .nv_wdata_o(nv_wdata_o));
  cmd_regs_props #(.ENTRY_CYCLES(ENTRY)) cmd_regs_props_i (.clk_i(clk_i), .rst_i(rst_i),
    .cmd_valid(link.cmd_valid), .cmd_byte(link.cmd_byte), .cmd_data(link.cmd_data),
    .rsp_valid(link.rsp_valid), .rsp_data(link.rsp_data), .command_mode_o(command_mode_o));

  // ==========================================================================
  // memory contents; address 0 stands for a reserved calibration word
  assign nv_rdata_i = mem[nv_addr_o];
  initial mem = '{16'h1234, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
                  16'h0000, 16'h0000, 16'hffc1, 16'h0400, 16'h0100, 16'h1300, 16'h0000,
                  16'h0000, 16'h0000};

  always @(posedge clk_i) begin
    if (nv_we_o === 1'h1) begin
      we_cnt++;
      we_addr = nv_addr_o;
      we_data = nv_wdata_o;
    end
  end

  // ==========================================================================
  // bus and compare tasks
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checks++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  // read data is taken at the edge that sees ack, before that edge's updates land
  task automatic wb(input logic we, input logic [7:0] adr, input logic [31:0] dat,
                    output logic [31:0] q);
    wb_cyc_i <= 1'h1;
    wb_stb_i <= 1'h1;
    wb_we_i  <= we;
    wb_adr_i <= adr;
    wb_dat_i <= dat;
    do @(posedge clk_i); while (wb_ack_o !== 1'h1);
    q = wb_dat_o;
    wb_cyc_i <= 1'h0;
    wb_stb_i <= 1'h0;
    @(posedge clk_i);
  endtask

  task automatic cmd(input logic [7:0] c, input logic [15:0] d, output logic [31:0] st);
    wb(1'h1, ADR_CMD, {d, 8'h00, c}, st);
    do wb(1'h0, ADR_STATUS, 32'h0000_0000, st); while (st[0] !== 1'h0);
  endtask

  task automatic rd(input logic [7:0] c, output logic [15:0] v);
    logic [31:0] q;
    cmd(c, 16'h0000, q);
    wb(1'h0, ADR_RDATA, 32'h0000_0000, q);
    v = q[15:0];
  endtask

  task automatic ctl(input logic [31:0] d);
    logic [31:0] q;
    wb(1'h1, ADR_CTRL, d, q);
  endtask

  // ==========================================================================
  // scenarios
  task automatic t_locked();
    logic [31:0] st;
    chk({command_mode_o, pump_clock_on_o, nv_write_en_o, nv_we_o}, 32'h0000_0000);
    cmd(CMD_CTRL_RD, 16'h0000, st);
    chk(st[3:0], 32'h0000_0008);
    ctl(32'h0000_0002);
    cmd(CMD_KEY_WR, 16'h16f5, st);
    chk(command_mode_o, 32'h0000_0000);
    cmd(CMD_KEY_WR, UNLOCK_KEY, st);
    chk(command_mode_o, 32'h0000_0001);
  endtask

  task automatic t_flags();
    logic [15:0] v;
    field_missing_i <= 1'h1;
    nv_single_err_i <= 1'h1;
    nv_readout_i    <= 1'h1;
    @(posedge clk_i);
    nv_readout_i    <= 1'h0;
    nv_single_err_i <= 1'h0;
    rd(CMD_CTRL_RD, v);
    chk(v, 32'h0000_0140);
    chk(diag_mode_o, 32'h0000_0000);
    field_check_en_i <= 1'h1;
    repeat (2) @(posedge clk_i);
    chk(diag_mode_o, 32'h0000_0001);
    bond_open_i     <= 1'h1;
    undervoltage_i  <= 1'h1;
    nv_double_err_i <= 1'h1;
    nv_readout_i    <= 1'h1;
    crc_mismatch_i  <= 1'h1;
    startup_check_i <= 1'h1;
    @(posedge clk_i);
    bond_open_i     <= 1'h0;
    nv_double_err_i <= 1'h0;
    nv_readout_i    <= 1'h0;
    crc_mismatch_i  <= 1'h0;
    startup_check_i <= 1'h0;
    rd(CMD_CTRL_RD, v);
    chk(v, 32'h0000_91f0);
    chk(diag_mode_o, 32'h0000_0001);
  endtask

  task automatic t_pump();
    logic [31:0] st;
    logic [15:0] v;
    cmd(CMD_CTRL_WR, 16'h0800, st);
    chk({st[2], pump_clock_on_o}, 32'h0000_0002);
    ctl(32'h0000_0002);
    cmd(8'h10, 16'h0001, st);
    chk({st[2], nv_we_o}, 32'h0000_0002);
    ctl(32'h0000_0002);
    cmd(CMD_TEST_WR, 16'h0800, st);
    chk(nv_write_en_o, 32'h0000_0001);
    cmd(CMD_CTRL_WR, 16'h6e0f, st);
    chk({pump_clock_on_o, diag_mode_o}, 32'h0000_0002);
    rd(CMD_CTRL_RD, v);
    chk(v, 32'h0000_99f0);
  endtask

  task automatic t_nv();
    logic [31:0] q;
    int          c0;
    c0 = we_cnt;
    cmd(8'h10, 16'hbeef, q);
    chk({we_addr, we_data}, 32'h0008_beef);
    cmd(8'h00, 16'h1111, q);
    cmd(8'h30, 16'h2222, q);
    chk(we_cnt - c0, 32'h0000_0001);
    wb(1'h1, 8'h40, 32'hffff_ffff, q);
    wb(1'h0, 8'h40, 32'h0000_0000, q);
    chk(q, 32'h0000_0000);
  endtask

  task automatic t_crc();
    logic [31:0] q;
    logic [15:0] v;
    ctl(32'h0000_0001);
    for (int a = 8; a < 16; a++) begin
      rd({3'h0, 4'(a), 1'h1}, v);
      chk(v, mem[a]);
    end
    wb(1'h0, ADR_STATUS, 32'h0000_0000, q);
    chk(q[15:8], 32'h0000_00a9);
    rd(8'h01, v);
    chk(v, mem[0]);
    rd(CMD_TEST_RD, v);
    chk(v, 32'h0000_0000);
  endtask

  // a late key must be ignored once the window has closed with no fault pending
  task automatic t_window();
    logic [31:0] st;
    rst_i           <= 1'h1;
    field_missing_i <= 1'h0;
    undervoltage_i  <= 1'h0;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'h0;
    repeat (ENTRY + 10) @(posedge clk_i);
    chk({command_mode_o, pump_clock_on_o, nv_write_en_o}, 32'h0000_0000);
    cmd(CMD_KEY_WR, UNLOCK_KEY, st);
    chk(command_mode_o, 32'h0000_0000);
    // a pending diagnostic condition lets the key in again without a reset
    undervoltage_i <= 1'h1;
    cmd(CMD_KEY_WR, UNLOCK_KEY, st);
    chk(command_mode_o, 32'h0000_0001);
  endtask

  task automatic end_sim();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // ==========================================================================
  // clock, watchdog and main sequence
  initial begin
    clk_i = 1'h0;
    forever #25 clk_i = ~clk_i;
  end

  initial begin
    repeat (30000) @(posedge clk_i);
    errors++;
    end_sim();
  end

  initial begin
    {wb_we_i, wb_cyc_i, wb_stb_i, wb_adr_i, wb_dat_i} = '0;
    {undervoltage_i, nv_readout_i, nv_single_err_i, nv_double_err_i} = '0;
    {field_missing_i, field_check_en_i, bond_open_i, startup_check_i, crc_mismatch_i} = '0;
    {errors, checks, we_cnt} = '0;
    wb_sel_i = 4'hf;
    rst_i    = 1'h1;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'h0;
    t_locked();
    t_flags();
    t_pump();
    t_nv();
    t_crc();
    t_window();
    end_sim();
  end

endmodule

`default_nettype wire
